// ### logic/tlf_pkg.sv
// Shared constants, address map and CRC step for the timing data link frame path.
package tlf_pkg;
	localparam int FRAME_BITS = 41;
	localparam int ID_BITS = 8;
	localparam int PAY_BITS = 24;
	localparam int CRC_BITS = 8;
	localparam int BODY_BITS = ID_BITS + PAY_BITS;
	localparam int TAIL_BITS = FRAME_BITS - 1;
	localparam int ENTRIES = 256;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic START_LEVEL = 1'b1;
	localparam logic IDLE_LEVEL = 1'b0;
	localparam int BIT_CYCLES_DEF = 20;

	localparam logic [31:0] PAY_BASE = 32'hF000_6000;
	localparam logic [31:0] FLAG_BASE = 32'hF000_6400;
	localparam logic [1:0] FLAG_LANE = 2'h3;
	localparam logic [31:0] ERR_HI_ADDR = 32'hF000_4051;
	localparam logic [31:0] ERR_LO_ADDR = 32'hF000_404D;
	localparam logic [31:0] IRQ_STAT_ADDR = 32'hF000_6803;
	localparam logic [31:0] IRQ_CLR_ADDR = 32'hF000_6807;
	localparam logic [31:0] IRQ_EN_ADDR = 32'hF000_680B;
	localparam int REGION_LSB = 10;

	localparam int FRESH_BIT = 0;
	localparam int GOOD_BIT = 1;
	localparam int IRQ_GOOD_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam int IRQ_BITS = 2;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	localparam logic [15:0] ERR_RESET = 16'h0000;

	function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
		logic fb;
		fb = crc[7] ^ din;
		crc_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
	endfunction
endpackage

// ### logic/tlf_link_if.sv
// Serial timing data link between the far-end transmitter and the frame receiver.
`timescale 1ns/1ps
interface tlf_link_if;
	logic line_bit;
	logic bit_strobe;
	modport tx (output line_bit, output bit_strobe);
	modport rx (input line_bit, input bit_strobe);
endinterface

// ### logic/tlf_frame_tx.sv
// Far-end transmitter that serialises one parameter frame per request.
`timescale 1ns/1ps
module tlf_frame_tx #(
	parameter int BIT_CYCLES = tlf_pkg::BIT_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	tlf_link_if.tx link,
	input wire logic send,
	input wire logic [7:0] send_id,
	input wire logic [23:0] send_payload,
	input wire logic corrupt_crc,
	output logic ready
);
	typedef enum logic [0:0] {TLF_TX_IDLE, TLF_TX_SEND} tlf_tx_state_t;

	// The divider is 16 bits wide, so slower bit rates cannot be served.
	if (BIT_CYCLES < 1 || BIT_CYCLES > 65535) begin : g_bad_rate
		$error("BIT_CYCLES out of range");
	end

	tlf_tx_state_t state_q;
	logic [15:0] div_q;
	logic [5:0] left_q;
	logic [tlf_pkg::FRAME_BITS-1:0] frame_q;
	logic [7:0] crc;
	logic tick;
	logic [tlf_pkg::BODY_BITS-1:0] body;

	assign body = {send_id, send_payload};
	assign tick = (div_q == 16'(BIT_CYCLES - 1));
	assign ready = (state_q == TLF_TX_IDLE);

	always_comb begin
		crc = tlf_pkg::CRC_INIT;
		for (int i = tlf_pkg::BODY_BITS - 1; i >= 0; i--) begin
			crc = tlf_pkg::crc_step(crc, body[i]);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 16'h0000;
		end else if (state_q == TLF_TX_IDLE || tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// Frames are sent only on request; pacing once per machine cycle is the user's job.
	// send request paces frames
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= TLF_TX_IDLE;
			left_q <= 6'h00;
			frame_q <= '0;
		end else if (state_q == TLF_TX_IDLE) begin
			if (send) begin
				state_q <= TLF_TX_SEND;
				left_q <= 6'(tlf_pkg::FRAME_BITS);
				frame_q <= {tlf_pkg::START_LEVEL, send_id, send_payload, crc ^ {7'h00, corrupt_crc}};
			end
		end else if (tick) begin
			frame_q <= {frame_q[tlf_pkg::FRAME_BITS-2:0], tlf_pkg::IDLE_LEVEL};
			left_q <= left_q - 6'h01;
			if (left_q == 6'h01) begin
				state_q <= TLF_TX_IDLE;
			end
		end
	end

	assign link.line_bit = (state_q == TLF_TX_SEND) ? frame_q[tlf_pkg::FRAME_BITS-1] : tlf_pkg::IDLE_LEVEL;
	assign link.bit_strobe = (state_q == TLF_TX_SEND) && tick;
endmodule

// ### logic/tlf_frame_rx.sv
// Frame receiver with payload buffer, per-ID flags, error counter and host port.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Function
// - frame is start, id, payload, crc
// - far end sends every machine cycle; tlf_frame_tx sends one frame per send request instead
// - 256 by 24 buffer indexed by id
// - check crc, match means valid
// - mismatch pulses error, counter increments
// - fresh flag bit0, good flag bit1
// - flags encode 00, 01, 11
// - hardware sets flags, host write clears
// - host clears flags after reading payload
// - payload slots from base, stride four
// - byte0 undefined, bytes 1-3 big-endian
// - byte or 16-bit word reads
// - flag byte at id times 4 plus 3
// - flag byte upper six bits zero
// - host may write payload to clear
// - host writes only zeros to payload
// - counter bytes at two read-only addresses
module tlf_frame_rx (
	input wire logic clk,
	input wire logic reset_n,
	tlf_link_if.rx link,
	input wire logic [31:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic host_word,
	input wire logic host_wr,
	input wire logic host_rd,
	output logic [15:0] host_rdata,
	output logic irq
);
	typedef enum logic [0:0] {TLF_RX_IDLE, TLF_RX_SHIFT} tlf_rx_state_t;

	tlf_rx_state_t state_q;
	logic [5:0] count_q;
	logic [tlf_pkg::TAIL_BITS-1:0] shift_q;
	logic [7:0] crc_q;
	logic commit_q;
	logic good_q;
	logic [7:0] cid_q;
	logic [23:0] cpay_q;
	logic [23:0] buf_q [tlf_pkg::ENTRIES];
	logic [1:0] flags_q [tlf_pkg::ENTRIES];
	logic [15:0] err_q;
	logic [tlf_pkg::IRQ_BITS-1:0] irq_stat_q;
	logic [tlf_pkg::IRQ_BITS-1:0] irq_en_q;
	logic [15:0] rdata_q;
	logic pay_hit;
	logic flag_hit;
	logic [7:0] idx;
	logic [1:0] lane;
	logic flag_clr;
	logic [tlf_pkg::IRQ_BITS-1:0] irq_events;
	logic [15:0] rd_val;
	logic [23:0] slot;

	assign idx = host_addr[9:2];
	assign lane = host_addr[1:0];
	assign pay_hit = host_addr[31:tlf_pkg::REGION_LSB] == tlf_pkg::PAY_BASE[31:tlf_pkg::REGION_LSB];
	assign flag_hit = host_addr[31:tlf_pkg::REGION_LSB] == tlf_pkg::FLAG_BASE[31:tlf_pkg::REGION_LSB];
	assign flag_clr = host_wr && flag_hit && !host_word && lane == tlf_pkg::FLAG_LANE;
	assign slot = buf_q[idx];

	// shift in the 40 bits after start
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= TLF_RX_IDLE;
			count_q <= 6'h00;
			shift_q <= '0;
		end else if (link.bit_strobe) begin
			if (state_q == TLF_RX_IDLE) begin
				if (link.line_bit == tlf_pkg::START_LEVEL) begin
					state_q <= TLF_RX_SHIFT;
					count_q <= 6'h00;
				end
			end else begin
				shift_q <= {shift_q[tlf_pkg::TAIL_BITS-2:0], link.line_bit};
				count_q <= count_q + 6'h01;
				if (count_q == 6'(tlf_pkg::TAIL_BITS - 1)) begin
					state_q <= TLF_RX_IDLE;
				end
			end
		end
	end

	// running crc over id and payload
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			crc_q <= tlf_pkg::CRC_INIT;
		end else if (link.bit_strobe) begin
			if (state_q == TLF_RX_IDLE) begin
				crc_q <= tlf_pkg::CRC_INIT;
			end else if (count_q < 6'(tlf_pkg::BODY_BITS)) begin
				crc_q <= tlf_pkg::crc_step(crc_q, link.line_bit);
			end
		end
	end

	// commit once the check byte is in
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			commit_q <= 1'b0;
			good_q <= 1'b0;
			cid_q <= 8'h00;
			cpay_q <= 24'h000000;
		end else begin
			commit_q <= 1'b0;
			if (link.bit_strobe && state_q == TLF_RX_SHIFT && count_q == 6'(tlf_pkg::TAIL_BITS - 1)) begin
				commit_q <= 1'b1;
				good_q <= crc_q == {shift_q[6:0], link.line_bit};
				cid_q <= shift_q[38:31];
				cpay_q <= shift_q[30:7];
			end
		end
	end

	// host writes reach the buffer
	// A frame commit wins over a host write in the same cycle; the host write is then lost.
	always_ff @(posedge clk) begin
		if (commit_q) begin
			buf_q[cid_q] <= cpay_q;
		end else if (host_wr && pay_hit) begin
			if (host_word) begin
				if (lane[1]) begin
					buf_q[idx][15:0] <= host_wdata;
				end else begin
					buf_q[idx][23:16] <= host_wdata[7:0];
				end
			end else begin
				unique case (lane)
					2'h1: buf_q[idx][23:16] <= host_wdata[7:0];
					2'h2: buf_q[idx][15:8] <= host_wdata[7:0];
					2'h3: buf_q[idx][7:0] <= host_wdata[7:0];
					default: ;
				endcase
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < tlf_pkg::ENTRIES; g++) begin : g_flags
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					flags_q[g] <= tlf_pkg::FLAGS_RESET;
				end else if (commit_q && cid_q == 8'(g)) begin
					// 01 on bad from clear, 11 on good; a bad frame keeps an earlier good bit
					flags_q[g][tlf_pkg::FRESH_BIT] <= 1'b1;
					flags_q[g][tlf_pkg::GOOD_BIT] <= flags_q[g][tlf_pkg::GOOD_BIT] | good_q;
				end else if (flag_clr && idx == 8'(g)) begin
					flags_q[g] <= tlf_pkg::FLAGS_RESET;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			err_q <= tlf_pkg::ERR_RESET;
		end else if (commit_q && !good_q) begin
			err_q <= err_q + 16'h0001;
		end
	end

	assign irq_events[tlf_pkg::IRQ_GOOD_BIT] = commit_q && good_q;
	assign irq_events[tlf_pkg::IRQ_ERR_BIT] = commit_q && !good_q;

	// Events take priority so one arriving during a clear is not dropped.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_events | (irq_stat_q &
				~((host_wr && !host_word && host_addr == tlf_pkg::IRQ_CLR_ADDR) ?
				host_wdata[tlf_pkg::IRQ_BITS-1:0] : '0));
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en_q <= '0;
		end else if (host_wr && !host_word && host_addr == tlf_pkg::IRQ_EN_ADDR) begin
			irq_en_q <= host_wdata[tlf_pkg::IRQ_BITS-1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	always_comb begin
		rd_val = 16'h0000;
		if (pay_hit) begin
			if (host_word) begin
				rd_val = lane[1] ? slot[15:0] : {8'h00, slot[23:16]};
			end else begin
				unique case (lane)
					2'h1: rd_val = {8'h00, slot[23:16]};
					2'h2: rd_val = {8'h00, slot[15:8]};
					2'h3: rd_val = {8'h00, slot[7:0]};
					default: rd_val = 16'h0000;
				endcase
			end
		end else if (flag_hit) begin
			if (!host_word && lane == tlf_pkg::FLAG_LANE) begin
				rd_val = {14'h0000, flags_q[idx]};
			end
		end else if (!host_word) begin
			unique case (host_addr)
				tlf_pkg::ERR_HI_ADDR: rd_val = {8'h00, err_q[15:8]};
				tlf_pkg::ERR_LO_ADDR: rd_val = {8'h00, err_q[7:0]};
				tlf_pkg::IRQ_STAT_ADDR: rd_val = {14'h0000, irq_stat_q};
				tlf_pkg::IRQ_EN_ADDR: rd_val = {14'h0000, irq_en_q};
				default: rd_val = 16'h0000;
			endcase
		end
	end

	// Read data is valid only in the cycle after the strobe, and is zero otherwise.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= host_rd ? rd_val : 16'h0000;
		end
	end

	assign host_rdata = rdata_q;
endmodule

// ### tb/tlf_link_sva.sv
// Checker for the framing and bit timing seen on the serial link.
`timescale 1ns/1ps
module tlf_link_sva #(
	parameter int BIT_CYCLES = tlf_pkg::BIT_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic line_bit,
	input wire logic bit_strobe
);
	logic [5:0] cnt_q;
	logic [15:0] gap_q;
	logic in_frame;
	// Back-to-back strobes would break the one-cycle and rest checks, so a rate of one is refused.
	if (BIT_CYCLES < 2 || BIT_CYCLES > 65534) begin : g_bad_rate
		$error("BIT_CYCLES outside the range this checker serves");
	end
	assign in_frame = cnt_q != 6'h00;
	// Counts the strobes of a frame, so that the 41st one closes it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 6'h00;
		end else if (bit_strobe && (in_frame || line_bit)) begin
			cnt_q <= (cnt_q == 6'h28) ? 6'h00 : cnt_q + 6'h01;
		end
	end
	// Saturates so that a long idle gap never wraps back to a legal spacing.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_q <= 16'h0000;
		end else if (bit_strobe) begin
			gap_q <= 16'h0001;
		end else if (gap_q != 16'hFFFF) begin
			gap_q <= gap_q + 16'h0001;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_quiet2;
		!bit_strobe [*2];
	endsequence
	a_reset_quiet: assert property ($rose(reset_n) |-> !line_bit && !bit_strobe)
		else $error("link active right after reset");
	a_strobe_one_cycle: assert property (bit_strobe |=> !bit_strobe)
		else $error("strobe longer than one cycle");
	a_bit_spacing: assert property ((bit_strobe && in_frame) |-> gap_q == BIT_CYCLES)
		else $error("wrong spacing between bit strobes");
	a_gap_bound: assert property (in_frame |-> gap_q <= BIT_CYCLES)
		else $error("bit strobe overdue inside a frame");
	a_bit_held: assert property ((in_frame && !bit_strobe) |=> $stable(line_bit))
		else $error("line changed inside a bit period");
	a_start_high: assert property ((bit_strobe && !in_frame) |-> line_bit)
		else $error("frame strobe without start bit");
	a_frame_rest: assert property ((bit_strobe && cnt_q == 6'h28) |=> s_quiet2)
		else $error("strobe too soon after the last frame bit");
	a_no_early_strobe: assert property (($rose(line_bit) && !in_frame) |-> !bit_strobe)
		else $error("start bit strobed in its first cycle");
endmodule

// ### tb/tb_timing_link_frame_receiver.sv
// Testbench joining the transmitter and the receiver across the serial link.
`timescale 1ns/1ps
module tb_timing_link_frame_receiver;
	localparam int BITS = 2;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic send = 1'b0;
	logic [7:0] send_id = 8'h00;
	logic [23:0] send_payload = 24'h000000;
	logic corrupt_crc = 1'b0;
	logic ready;
	logic [31:0] host_addr = 32'h00000000;
	logic [15:0] host_wdata = 16'h0000;
	logic host_word = 1'b0;
	logic host_wr = 1'b0;
	logic host_rd = 1'b0;
	logic [15:0] host_rdata;
	logic irq;
	int mismatches = 0;
	int comparisons = 0;
	tlf_link_if link ();
	tlf_frame_tx #(.BIT_CYCLES(BITS)) tlf_frame_tx_i (.clk(clk), .reset_n(reset_n), .link(link), .send(send),
		.send_id(send_id), .send_payload(send_payload), .corrupt_crc(corrupt_crc), .ready(ready));
	tlf_frame_rx tlf_frame_rx_i (.clk(clk), .reset_n(reset_n), .link(link), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_word(host_word), .host_wr(host_wr), .host_rd(host_rd),
		.host_rdata(host_rdata), .irq(irq));
	tlf_link_sva #(.BIT_CYCLES(BITS)) tlf_link_sva_i (.clk(clk), .reset_n(reset_n), .line_bit(link.line_bit),
		.bit_strobe(link.bit_strobe));
	always #2.5 clk = ~clk;
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = tlf_pkg::CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? tlf_pkg::CRC_POLY : 8'h00);
		end
		return c;
	endfunction
	task automatic close_out;
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic w = 1'b0);
		@(posedge clk);
		host_addr <= a;
		host_wdata <= d;
		host_word <= w;
		host_wr <= 1'b1;
		@(posedge clk);
		host_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [31:0] a, input logic w, input logic [15:0] exp);
		@(posedge clk);
		host_addr <= a;
		host_word <= w;
		host_rd <= 1'b1;
		@(posedge clk);
		host_rd <= 1'b0;
		#1;
		chk($sformatf("read %h", a), exp, host_rdata);
	endtask
	// Sends one frame and compares every wire bit with the expected frame.
	task automatic frame(input logic [7:0] id, input logic [23:0] pay, input logic bad);
		logic [40:0] exp;
		logic [40:0] seen;
		int n;
		int guard;
		exp = {1'b1, id, pay, crc8({id, pay}) ^ {7'h00, bad}};
		seen = 41'h00000000000;
		n = 0;
		guard = 0;
		@(posedge clk);
		send <= 1'b1;
		send_id <= id;
		send_payload <= pay;
		corrupt_crc <= bad;
		@(posedge clk);
		send <= 1'b0;
		#1;
		chk("tx busy", 16'h0000, {15'h0000, ready});
		while (n < 41 && guard < 1000) begin
			@(negedge clk);
			guard++;
			if (link.bit_strobe === 1'b1) begin
				seen = {seen[39:0], link.line_bit};
				n++;
			end
		end
		chk("frame strobes", 16'h0029, 16'(n));
		chk("frame head", {7'h00, exp[40:32]}, {7'h00, seen[40:32]});
		chk("frame body", exp[31:16], seen[31:16]);
		chk("frame tail", exp[15:0], seen[15:0]);
		repeat (3) @(posedge clk);
		#1;
		chk("tx idle", 16'h0001, {15'h0000, ready});
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		rd(32'hF000642B, 1'b0, 16'h0000);
		rd(tlf_pkg::ERR_LO_ADDR, 1'b0, 16'h0000);
		wr(32'hF0006029, 16'h0000);
		wr(32'hF000602A, 16'h0000);
		wr(32'hF000602B, 16'h0000);
		rd(32'hF0006028, 1'b1, 16'h0000);
		rd(32'hF000602A, 1'b1, 16'h0000);
		wr(32'hF0006004, 16'h0000, 1'b1);
		wr(32'hF0006006, 16'h0000, 1'b1);
		rd(32'hF0006005, 1'b0, 16'h0000);
		rd(32'hF0006006, 1'b1, 16'h0000);
		wr(tlf_pkg::IRQ_EN_ADDR, 16'h0002);
		rd(tlf_pkg::IRQ_EN_ADDR, 1'b0, 16'h0002);
		frame(8'h0A, 24'h123456, 1'b0);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		rd(32'hF0006028, 1'b0, 16'h0000);
		rd(32'hF0006029, 1'b0, 16'h0012);
		rd(32'hF000602A, 1'b0, 16'h0034);
		rd(32'hF000602B, 1'b0, 16'h0056);
		rd(32'hF0006028, 1'b1, 16'h0012);
		rd(32'hF000602A, 1'b1, 16'h3456);
		rd(32'hF000642B, 1'b0, 16'h0003);
		rd(tlf_pkg::IRQ_STAT_ADDR, 1'b0, 16'h0001);
		wr(32'hF000642B, 16'h0000);
		rd(32'hF000642B, 1'b0, 16'h0000);
		frame(8'hFF, 24'hABCDEF, 1'b1);
		rd(32'hF00067FF, 1'b0, 16'h0001);
		rd(32'hF00063FF, 1'b0, 16'h00EF);
		rd(tlf_pkg::ERR_LO_ADDR, 1'b0, 16'h0001);
		rd(tlf_pkg::ERR_LO_ADDR, 1'b0, 16'h0001);
		rd(tlf_pkg::ERR_HI_ADDR, 1'b0, 16'h0000);
		chk("irq raised", 16'h0001, {15'h0000, irq});
		rd(tlf_pkg::IRQ_STAT_ADDR, 1'b0, 16'h0003);
		wr(tlf_pkg::IRQ_CLR_ADDR, 16'h0003);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		rd(tlf_pkg::IRQ_STAT_ADDR, 1'b0, 16'h0000);
		wr(tlf_pkg::ERR_LO_ADDR, 16'h00FF);
		rd(tlf_pkg::ERR_LO_ADDR, 1'b0, 16'h0001);
		rd(32'hF0005000, 1'b0, 16'h0000);
		frame(8'h0A, 24'h654321, 1'b0);
		rd(32'hF000642B, 1'b0, 16'h0003);
		rd(32'hF000602A, 1'b1, 16'h4321);
		frame(8'h0A, 24'h000000, 1'b1);
		rd(32'hF000642B, 1'b0, 16'h0003);
		rd(tlf_pkg::ERR_LO_ADDR, 1'b0, 16'h0002);
		chk("irq on error", 16'h0001, {15'h0000, irq});
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		#1;
		chk("irq in reset", 16'h0000, {15'h0000, irq});
		@(posedge clk);
		reset_n <= 1'b1;
		rd(32'hF000642B, 1'b0, 16'h0000);
		rd(tlf_pkg::ERR_LO_ADDR, 1'b0, 16'h0000);
		rd(tlf_pkg::IRQ_EN_ADDR, 1'b0, 16'h0000);
		close_out;
	end
	// The tests need about 450 cycles; this span is some forty times that.
	initial begin
		#100000;
		mismatches++;
		close_out;
	end
endmodule
